// ### core/chsup_status.sv
// Status pin encoder: sleep off, faults blink, permit high on
`timescale 1ns/1ps
`default_nettype none
module chsup_status (
	input wire logic clk,
	input wire logic rst,
	input wire logic blink_tick,
	input wire logic sleep,
	input wire logic fault_blink,
	output logic stat_oe_n
);
	typedef struct packed {
		logic phase_ff;
		logic oe_n_ff;
	} chsup_sts_t;
	chsup_sts_t q_ff, nxt_q;
	always_comb begin
		nxt_q = q_ff;
		if (blink_tick) begin
			nxt_q.phase_ff = !q_ff.phase_ff;
		end
		if (sleep) begin
			nxt_q.oe_n_ff = 1'b1;
		end else if (fault_blink) begin
			nxt_q.oe_n_ff = !q_ff.phase_ff;
		end else begin
			nxt_q.oe_n_ff = 1'b0;
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q_ff <= '{phase_ff: 1'b0, oe_n_ff: 1'b1};
		end else begin
			q_ff <= nxt_q;
		end
	end
	assign stat_oe_n = q_ff.oe_n_ff;
	sleep_off_a: assert property (@(posedge clk) disable iff (rst)
		sleep |=> stat_oe_n) else $error("status driven in sleep");
	steady_on_a: assert property (@(posedge clk) disable iff (rst)
		(!sleep && !fault_blink) |=> !stat_oe_n) else $error("status not on");
endmodule
`default_nettype wire

// ### core/chsup_timer.sv
// Cycle counter that pulses once at terminal count, with clear
`timescale 1ns/1ps
`default_nettype none
module chsup_timer #(
	parameter int COUNT = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic run,
	input wire logic clr,
	output logic tick
);
	typedef struct packed {
		logic [31:0] cnt_ff;
		logic tick_ff;
	} chsup_tmr_t;
	chsup_tmr_t q_ff, nxt_q;
	always_comb begin
		nxt_q = q_ff;
		nxt_q.tick_ff = 1'b0;
		if (clr || !run) begin
			nxt_q.cnt_ff = 32'h0;
		end else if (q_ff.cnt_ff == 32'(COUNT - 1)) begin
			nxt_q.cnt_ff = 32'h0;
			nxt_q.tick_ff = 1'b1;
		end else begin
			nxt_q.cnt_ff = q_ff.cnt_ff + 32'h1;
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q_ff <= '0;
		end else begin
			q_ff <= nxt_q;
		end
	end
	assign tick = q_ff.tick_ff;
	tick_spacing_a: assert property (@(posedge clk) disable iff (rst)
		tick |=> !tick) else $error("timer tick lasted more than one cycle");
endmodule
`default_nettype wire

// ### core/chsup_top.sv
// Supervisory control for a switched-mode capacitor charger
`timescale 1ns/1ps
`default_nettype none
module chsup_top #(
	parameter int PWRUP_CYCLES = chsup_pkg::PWRUP_CYC,
	parameter int STEP_CYCLES = chsup_pkg::STEP_CYC,
	parameter int BLINK_HALF_CYCLES = chsup_pkg::BLINK_HALF_CYC
) (
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic CHARGE_PERMIT,
	input wire logic SUPPLY_ABOVE_SUPPLY_UNDERVOLTAGE_LOCK,
	input wire logic SENSE_NEG_ABOVE_SUPPLY,
	input wire logic INPUT_OVERVOLTAGE,
	input wire logic OUTPUT_ABOVE_OV,
	input wire logic OUTPUT_BELOW_102,
	input wire logic OVERCURRENT_160,
	input wire logic DIE_ABOVE_145,
	input wire logic DIE_BELOW_130,
	input wire logic THERM_ABOVE_COLD,
	input wire logic THERM_ABOVE_HOT_START,
	input wire logic THERM_ABOVE_HOT_CUTOFF,
	input wire logic FEEDBACK_BELOW_TARGET,
	input wire logic ZERO_DUTY,
	input wire logic PWM_DEMAND,
	input wire logic BOOT_RECHARGE,
	output logic HIGH_SIDE_ON,
	output logic LOW_SIDE_ON,
	output logic DISCHARGE_SINK_ON,
	output logic CHARGING,
	output logic CC_MODE,
	output logic CV_MODE,
	output logic [3:0] CURRENT_LIMIT_STEP,
	output logic SUPPLY_GOOD_OE_N,
	output logic SUPPLY_GOOD_OUT,
	output logic STATUS_OE_N,
	output logic STATUS_OUT
);
	typedef struct packed {
		chsup_pkg::chsup_st_t st_ff;
		chsup_pkg::chsup_mode_t mode_ff;
		logic permit_d_ff;
		logic pwrup_done_ff;
		logic die_hot_ff;
		logic out_ov_ff;
		logic [3:0] ss_ff;
		logic hs_ff;
		logic ls_ff;
		logic sink_ff;
		logic pg_oe_n_ff;
	} chsup_state_t;
	chsup_state_t q_ff, nxt_q;
	logic pwr_tick, step_tick, blink_tick;
	logic permit_fall, sleep, start_ok, run_ok, therm_start_ok, therm_run_ok, blink_fault;

	// Charge permit is taken as low when floating by the pin pulldown
	assign permit_fall = q_ff.permit_d_ff && !CHARGE_PERMIT;
	assign sleep = SENSE_NEG_ABOVE_SUPPLY;
	assign therm_start_ok = THERM_ABOVE_COLD && !THERM_ABOVE_HOT_START;
	assign therm_run_ok = THERM_ABOVE_COLD && !THERM_ABOVE_HOT_CUTOFF;
	// Shared qualifiers for starting and continuing a charge
	assign run_ok = CHARGE_PERMIT && SUPPLY_ABOVE_SUPPLY_UNDERVOLTAGE_LOCK && !sleep && !INPUT_OVERVOLTAGE
		&& q_ff.pwrup_done_ff && !q_ff.die_hot_ff && !permit_fall;
	assign start_ok = run_ok && therm_start_ok;
	assign blink_fault = !CHARGE_PERMIT || INPUT_OVERVOLTAGE || q_ff.out_ov_ff
		|| q_ff.die_hot_ff || q_ff.st_ff == chsup_pkg::CHSUP_SUSP;

	chsup_timer #(.COUNT(PWRUP_CYCLES)) u_pwrup (
		.clk(CORE_CLK),
		.rst(RST),
		.run(!q_ff.pwrup_done_ff),
		.clr(1'b0),
		.tick(pwr_tick)
	);
	chsup_timer #(.COUNT(STEP_CYCLES)) u_step (
		.clk(CORE_CLK),
		.rst(RST),
		.run(q_ff.st_ff == chsup_pkg::CHSUP_CHARGE && q_ff.ss_ff != chsup_pkg::SS_FULL),
		.clr(permit_fall),
		.tick(step_tick)
	);
	chsup_timer #(.COUNT(BLINK_HALF_CYCLES)) u_blink (
		.clk(CORE_CLK),
		.rst(RST),
		.run(1'b1),
		.clr(1'b0),
		.tick(blink_tick)
	);
	chsup_status u_status (
		.clk(CORE_CLK),
		.rst(RST),
		.blink_tick(blink_tick),
		.sleep(sleep),
		.fault_blink(blink_fault),
		.stat_oe_n(STATUS_OE_N)
	);

	always_comb begin
		nxt_q = q_ff;
		nxt_q.permit_d_ff = CHARGE_PERMIT;
		if (pwr_tick) begin
			nxt_q.pwrup_done_ff = 1'b1;
		end
		// Hysteresis: set above 145, cleared only below 130
		if (DIE_ABOVE_145) begin
			nxt_q.die_hot_ff = 1'b1;
		end else if (DIE_BELOW_130) begin
			nxt_q.die_hot_ff = 1'b0;
		end
		// Latched until output drops under 102 percent or permit falls; new overvoltage wins
		if (OUTPUT_ABOVE_OV) begin
			nxt_q.out_ov_ff = 1'b1;
		end else if (OUTPUT_BELOW_102 || permit_fall) begin
			nxt_q.out_ov_ff = 1'b0;
		end
		case (q_ff.st_ff)
			chsup_pkg::CHSUP_IDLE: begin
				if (start_ok) begin
					nxt_q.st_ff = chsup_pkg::CHSUP_CHARGE;
					nxt_q.ss_ff = chsup_pkg::SS_START;
				end else if (run_ok) begin
					nxt_q.st_ff = chsup_pkg::CHSUP_SUSP;
				end
			end
			chsup_pkg::CHSUP_CHARGE: begin
				if (!run_ok) begin
					nxt_q.st_ff = chsup_pkg::CHSUP_IDLE;
					nxt_q.ss_ff = 4'h0;
				end else if (!therm_run_ok) begin
					nxt_q.st_ff = chsup_pkg::CHSUP_SUSP;
					nxt_q.ss_ff = 4'h0;
				end else if (step_tick && q_ff.ss_ff != chsup_pkg::SS_FULL) begin
					nxt_q.ss_ff = q_ff.ss_ff + 4'h1;
				end
			end
			chsup_pkg::CHSUP_SUSP: begin
				if (!run_ok) begin
					nxt_q.st_ff = chsup_pkg::CHSUP_IDLE;
				end else if (therm_start_ok) begin
					nxt_q.st_ff = chsup_pkg::CHSUP_CHARGE;
					nxt_q.ss_ff = chsup_pkg::SS_START;
				end
			end
			default: begin
				nxt_q.st_ff = chsup_pkg::CHSUP_IDLE;
				nxt_q.ss_ff = 4'h0;
			end
		endcase
		if (nxt_q.st_ff != chsup_pkg::CHSUP_CHARGE) begin
			nxt_q.mode_ff = chsup_pkg::CHSUP_OFF;
		end else if (FEEDBACK_BELOW_TARGET) begin
			nxt_q.mode_ff = chsup_pkg::CHSUP_CC;
		end else if (!OUTPUT_ABOVE_OV) begin
			nxt_q.mode_ff = chsup_pkg::CHSUP_CV;
		end else begin
			nxt_q.mode_ff = chsup_pkg::CHSUP_OFF;
		end
		nxt_q.sink_ff = nxt_q.st_ff == chsup_pkg::CHSUP_CHARGE;
		// Gate drive: suspend turns both switches off; zero duty leaves only the bootstrap pulse
		if (nxt_q.st_ff != chsup_pkg::CHSUP_CHARGE) begin
			nxt_q.hs_ff = 1'b0;
			nxt_q.ls_ff = 1'b0;
		end else if (ZERO_DUTY) begin
			nxt_q.hs_ff = 1'b0;
			nxt_q.ls_ff = BOOT_RECHARGE;
		end else begin
			nxt_q.hs_ff = PWM_DEMAND && !OVERCURRENT_160 && !nxt_q.out_ov_ff;
			nxt_q.ls_ff = !nxt_q.hs_ff && (!PWM_DEMAND || BOOT_RECHARGE);
		end
		nxt_q.pg_oe_n_ff = !(SUPPLY_ABOVE_SUPPLY_UNDERVOLTAGE_LOCK && !SENSE_NEG_ABOVE_SUPPLY);
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			q_ff <= '{st_ff: chsup_pkg::CHSUP_IDLE, mode_ff: chsup_pkg::CHSUP_OFF,
				pg_oe_n_ff: 1'b1, default: '0};
		end else begin
			q_ff <= nxt_q;
		end
	end

	// Open-drain pins only ever pull low
	assign HIGH_SIDE_ON = q_ff.hs_ff;
	assign LOW_SIDE_ON = q_ff.ls_ff;
	assign DISCHARGE_SINK_ON = q_ff.sink_ff;
	assign CHARGING = q_ff.st_ff == chsup_pkg::CHSUP_CHARGE;
	assign CC_MODE = q_ff.mode_ff == chsup_pkg::CHSUP_CC;
	assign CV_MODE = q_ff.mode_ff == chsup_pkg::CHSUP_CV;
	assign CURRENT_LIMIT_STEP = q_ff.ss_ff;
	assign SUPPLY_GOOD_OE_N = q_ff.pg_oe_n_ff;
	assign SUPPLY_GOOD_OUT = 1'b0;
	assign STATUS_OUT = 1'b0;

	zero_duty_off_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		(ZERO_DUTY && !BOOT_RECHARGE) |=> !HIGH_SIDE_ON && !LOW_SIDE_ON)
		else $error("switch on at zero duty");
	in_ov_stop_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		INPUT_OVERVOLTAGE |=> !CHARGING) else $error("charging during input overvoltage");
	out_ov_block_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		OUTPUT_ABOVE_OV |=> !HIGH_SIDE_ON) else $error("high side on in overvoltage");
	sink_follows_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		DISCHARGE_SINK_ON == CHARGING) else $error("sink not matching charge");
	overcur_cut_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		OVERCURRENT_160 |=> !HIGH_SIDE_ON) else $error("high side on in overcurrent");
	die_hyst_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		DIE_ABOVE_145 ##1 (!DIE_BELOW_130)[*2] |=> !CHARGING)
		else $error("charging before die cooled");
	start_window_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		(!CHARGING && $rose(CHARGING) == 1'b0 ##1 $rose(CHARGING)) |->
		$past(THERM_ABOVE_COLD) && !$past(THERM_ABOVE_HOT_START))
		else $error("start outside thermistor window");
	cutoff_stop_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		(CHARGING && THERM_ABOVE_HOT_CUTOFF) |=> !CHARGING)
		else $error("charging past hot cutoff");
	permit_low_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		!CHARGE_PERMIT |=> !CHARGING && !HIGH_SIDE_ON) else $error("charge without permit");
	fall_clear_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		$fell(CHARGE_PERMIT) && !OUTPUT_ABOVE_OV |=> !q_ff.out_ov_ff)
		else $error("fault kept after permit fall");
	supply_good_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		SUPPLY_ABOVE_SUPPLY_UNDERVOLTAGE_LOCK && !SENSE_NEG_ABOVE_SUPPLY |=> !SUPPLY_GOOD_OE_N)
		else $error("supply good not asserted");
	mode_cc_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		CC_MODE |-> CHARGING && !CV_MODE) else $error("constant current out of charge");
	pwrup_hold_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		!q_ff.pwrup_done_ff |-> !CHARGING) else $error("charge before power-up delay");
	sleep_stop_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		SENSE_NEG_ABOVE_SUPPLY |=> !CHARGING) else $error("charging in sleep");
	ramp_start_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		$rose(CHARGING) |-> CURRENT_LIMIT_STEP == chsup_pkg::SS_START)
		else $error("ramp not restarted");
endmodule
`default_nettype wire

// ### inc/chsup_pkg.sv
// Package of constants for the charger supervisor
// Notes on behaviour
// - Zero duty demand keeps both switches off except the bootstrap recharge pulse.
// - Input supply at overvoltage threshold disables charging.
// - After output overvoltage, block high side until output below 102 percent.
// - Discharge sink on the output sense node is on exactly while charging.
// - Current above 160 percent of setpoint kills high side; resumes when below.
// - Die above 145 C shuts converter off until below 130 C.
// - New charge starts only with thermistor between cold and hot-start limits.
// - While charging, leaving cold-to-cutoff suspends until back in start window.
// - Suspending charge turns off both switching transistors.
// - Charging starts only with charge permit high and all other conditions met.
// - Falling edge of charge permit clears timers and latched faults; the code clears only the step timer and the output overvoltage latch.
// - An unconnected charge permit reads low, so charging stays off.
// - Supply-good pulled on when supply above undervoltage lock and sense-neg node.
// - Status on with permit high, off in sleep, blinking on faults or permit low.
// - Enabled with feedback below target gives constant current regulation.
// - Feedback at or above target but below overvoltage rise gives constant voltage.
// - Charging held off until 30 ms after power-up.
// - Sense-neg node above supply means sleep; no charging in sleep.
// - Each charge start ramps current limit in 8 steps of 1.6 ms.
package chsup_pkg;
	localparam int CLK_HZ = 40000000;
	localparam int PWRUP_MS = 30;
	localparam int PWRUP_CYC = PWRUP_MS * (CLK_HZ / 1000);
	localparam int STEP_US = 1600;
	localparam int STEP_CYC = STEP_US * (CLK_HZ / 1000000);
	localparam int SS_STEPS = 8;
	localparam int BLINK_MS = 1000;
	localparam int BLINK_HALF_CYC = (BLINK_MS / 2) * (CLK_HZ / 1000);
	localparam logic [3:0] SS_FULL = 4'h8;
	localparam logic [3:0] SS_START = 4'h1;
	typedef enum logic [1:0] {CHSUP_IDLE, CHSUP_CHARGE, CHSUP_SUSP} chsup_st_t;
	typedef enum logic [1:0] {CHSUP_OFF, CHSUP_CC, CHSUP_CV} chsup_mode_t;
endpackage

// ### testbench/chsup_host_model.sv
// Host side of the status pins: pull-ups on flags, pulldown on permit
`timescale 1ns/1ps
`default_nettype none
module chsup_host_model (
	input wire logic sg_oe_n,
	input wire logic sg_out,
	input wire logic st_oe_n,
	input wire logic st_out,
	input wire logic permit_drv,
	input wire logic permit_req,
	output logic sg_pin,
	output logic st_pin,
	output logic permit_pin
);
	// Released pins read the pull-up, never the last driven level
	assign sg_pin = sg_oe_n ? 1'h1 : sg_out;
	assign st_pin = st_oe_n ? 1'h1 : st_out;
	// A floating permit pin falls to the pulldown
	assign permit_pin = permit_drv ? permit_req : 1'h0;
endmodule
`default_nettype wire

// ### testbench/test_chsup_top.sv
// Scenario bench for the charger supervisor
`timescale 1ns/1ps
`default_nettype none
module test_chsup_top;
	logic clk, rst, preq, pdrv, sup, slp, inov, oov, o102, oc, dh, dc;
	logic tc, ths, tco, fbl, zd, pwm, boot;
	logic hs, ls, sink, chg, cc, cv, sgo, sgd, sto, std, sgp, stp, pp;
	logic [3:0] step;
	int failures = 0;
	int samples_checked = 0;
	chsup_top #(.PWRUP_CYCLES(50), .STEP_CYCLES(8), .BLINK_HALF_CYCLES(4)) dut (
		.CORE_CLK(clk), .RST(rst), .CHARGE_PERMIT(pp), .SUPPLY_ABOVE_SUPPLY_UNDERVOLTAGE_LOCK(sup),
		.SENSE_NEG_ABOVE_SUPPLY(slp), .INPUT_OVERVOLTAGE(inov), .OUTPUT_ABOVE_OV(oov),
		.OUTPUT_BELOW_102(o102), .OVERCURRENT_160(oc), .DIE_ABOVE_145(dh),
		.DIE_BELOW_130(dc), .THERM_ABOVE_COLD(tc), .THERM_ABOVE_HOT_START(ths),
		.THERM_ABOVE_HOT_CUTOFF(tco), .FEEDBACK_BELOW_TARGET(fbl), .ZERO_DUTY(zd),
		.PWM_DEMAND(pwm), .BOOT_RECHARGE(boot), .HIGH_SIDE_ON(hs), .LOW_SIDE_ON(ls),
		.DISCHARGE_SINK_ON(sink), .CHARGING(chg), .CC_MODE(cc), .CV_MODE(cv),
		.CURRENT_LIMIT_STEP(step), .SUPPLY_GOOD_OE_N(sgo), .SUPPLY_GOOD_OUT(sgd),
		.STATUS_OE_N(sto), .STATUS_OUT(std));
	chsup_host_model host (.sg_oe_n(sgo), .sg_out(sgd), .st_oe_n(sto), .st_out(std),
		.permit_drv(pdrv), .permit_req(preq), .sg_pin(sgp), .st_pin(stp), .permit_pin(pp));
	always #12.5 clk = ~clk;
	task automatic give_verdict;
		$display("checked %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic chk1(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: bit %b want %b", $time, got, exp);
		end
	endtask
	task automatic chk4(input logic [3:0] got, input logic [3:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: step %h want %h", $time, got, exp);
		end
	endtask
	// Bounded wait on the charging flag; a hang ends the run
	task automatic wait_chg(input logic v, input int lim);
		int i;
		i = 0;
		while (chg !== v && i < lim) begin
			tick(1);
			i++;
		end
		if (chg !== v) begin
			failures++;
			$display("Error at %0t: charge wait timed out", $time);
			give_verdict();
		end
	endtask
	// Low samples of the status pin over three blink half periods
	task automatic st_lows(output int lo);
		lo = 0;
		repeat (12) begin
			tick(1);
			if (stp === 1'h0)
				lo++;
		end
	endtask
	task automatic t_start;
		int i;
		tick(2);
		chk1(sgp, 1'h0);
		tick(40);
		chk1(chg, 1'h0);
		wait_chg(1'h1, 30);
		chk4(step, 4'h1);
		chk1(sink, 1'h1);
		chk1(cc, 1'h1);
		chk1(hs, 1'h1);
		i = 1;
		while (step !== 4'h8 && i < 80) begin
			tick(1);
			i++;
		end
		chk1(i >= 54 && i <= 58, 1'h1);
		fbl = 1'h0;
		tick(2);
		chk1(cv, 1'h1);
		chk1(cc, 1'h0);
		fbl = 1'h1;
		st_lows(i);
		chk1(i == 12, 1'h1);
	endtask
	task automatic t_guard;
		int lo;
		oc = 1'h1;
		tick(1);
		chk1(hs, 1'h0);
		oc = 1'h0;
		tick(2);
		chk1(hs, 1'h1);
		oov = 1'h1;
		o102 = 1'h0;
		tick(1);
		chk1(hs, 1'h0);
		oov = 1'h0;
		tick(3);
		chk1(hs, 1'h0);
		o102 = 1'h1;
		tick(2);
		chk1(hs, 1'h1);
		oov = 1'h1;
		o102 = 1'h0;
		tick(1);
		oov = 1'h0;
		preq = 1'h0;
		tick(2);
		chk1(chg, 1'h0);
		st_lows(lo);
		chk1(lo > 0 && lo < 12, 1'h1);
		preq = 1'h1;
		wait_chg(1'h1, 10);
		tick(1);
		chk1(hs, 1'h1);
		o102 = 1'h1;
		zd = 1'h1;
		tick(2);
		chk1(hs, 1'h0);
		chk1(ls, 1'h0);
		boot = 1'h1;
		tick(2);
		chk1(ls, 1'h1);
		chk1(hs, 1'h0);
		zd = 1'h0;
		boot = 1'h0;
	endtask
	task automatic t_faults;
		int lo;
		inov = 1'h1;
		tick(2);
		chk1(chg, 1'h0);
		chk1(hs | ls, 1'h0);
		chk1(sink, 1'h0);
		st_lows(lo);
		chk1(lo > 0 && lo < 12, 1'h1);
		inov = 1'h0;
		wait_chg(1'h1, 10);
		chk4(step, 4'h1);
		dh = 1'h1;
		dc = 1'h0;
		tick(2);
		chk1(chg, 1'h0);
		dh = 1'h0;
		tick(4);
		chk1(chg, 1'h0);
		dc = 1'h1;
		wait_chg(1'h1, 10);
	endtask
	task automatic t_therm;
		ths = 1'h1;
		tick(3);
		chk1(chg, 1'h1);
		tco = 1'h1;
		tick(2);
		chk1(chg, 1'h0);
		chk1(hs | ls, 1'h0);
		tco = 1'h0;
		tick(3);
		chk1(chg, 1'h0);
		ths = 1'h0;
		wait_chg(1'h1, 10);
		chk4(step, 4'h1);
		tc = 1'h0;
		tick(2);
		chk1(chg, 1'h0);
		tc = 1'h1;
		wait_chg(1'h1, 10);
	endtask
	task automatic t_idle;
		int lo;
		pdrv = 1'h0;
		tick(6);
		chk1(chg, 1'h0);
		slp = 1'h1;
		tick(2);
		chk1(sgp, 1'h1);
		st_lows(lo);
		chk1(lo == 0, 1'h1);
		pdrv = 1'h1;
		tick(4);
		chk1(chg, 1'h0);
		slp = 1'h0;
		sup = 1'h0;
		tick(2);
		chk1(sgp, 1'h1);
		sup = 1'h1;
		tick(2);
		chk1(sgp, 1'h0);
	endtask
	initial begin
		{clk, inov, oov, oc, dh, ths, tco, zd, boot, slp} = '0;
		{rst, preq, pdrv, sup, o102, dc, tc, fbl, pwm} = '1;
		tick(5);
		rst = 1'h0;
		t_start();
		t_guard();
		t_faults();
		t_therm();
		t_idle();
		give_verdict();
	end
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		$display("Error at %0t: run timed out", $time);
		give_verdict();
	end
endmodule
`default_nettype wire
